/* File: verilog/borc_pkg.sv */
// borc_pkg: constants, types and register map of the brown-out reset control
package borc_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int unsigned BORC_CLK_PERIOD_NS = 50;
  // brownout_min_duration, a least time: rounds up
  localparam int unsigned BORC_MIN_DUR_NS    = 200;
  localparam int unsigned BORC_MIN_DUR_CYC   =
    (BORC_MIN_DUR_NS + BORC_CLK_PERIOD_NS - 1) / BORC_CLK_PERIOD_NS;
  // powerup_delay_time, a least time: rounds up
  localparam int unsigned BORC_POWERUP_DELAY_TIMER_NS       = 1000000;
  localparam int unsigned BORC_POWERUP_DELAY_TIMER_CYC      =
    (BORC_POWERUP_DELAY_TIMER_NS + BORC_CLK_PERIOD_NS - 1) / BORC_CLK_PERIOD_NS;
  localparam int unsigned BORC_CNT_W         = 32;

  // ------------------------------------------------------------
  // brownout_enable_cfg encodings
  // ------------------------------------------------------------
  localparam logic [1:0] BORC_EN_OFF   = 2'h0;
  localparam logic [1:0] BORC_EN_SW    = 2'h1;
  localparam logic [1:0] BORC_EN_NOSLP = 2'h2;
  localparam logic [1:0] BORC_EN_ON    = 2'h3;

  // ------------------------------------------------------------
  // register map, byte addresses
  // ------------------------------------------------------------
  localparam int unsigned BORC_ADR_W        = 8;
  localparam logic [7:0]  BORC_ADR_CTRL     = 8'h00;
  localparam logic [7:0]  BORC_ADR_CFG      = 8'h04;
  localparam logic [7:0]  BORC_ADR_STATUS   = 8'h08;
  localparam logic [7:0]  BORC_ADR_IRQ_STAT = 8'h0C;
  localparam logic [7:0]  BORC_ADR_IRQ_MASK = 8'h10;

  // reset_control_reg fields
  localparam int unsigned BORC_CTRL_BORF    = 0;
  localparam int unsigned BORC_CTRL_PORF    = 1;
  localparam int unsigned BORC_CTRL_SWEN    = 6;
  localparam logic        BORC_SWEN_RST     = 1'b1;
  localparam logic        BORC_BORF_RST     = 1'b0;
  localparam logic        BORC_PORF_RST     = 1'b0;

  // status register fields
  localparam int unsigned BORC_ST_LOW       = 0;
  localparam int unsigned BORC_ST_DET_EN    = 1;
  localparam int unsigned BORC_ST_RESET     = 2;
  localparam int unsigned BORC_ST_STATE_LSB = 4;

  // interrupt bits
  localparam int unsigned BORC_IRQ_W        = 2;
  localparam int unsigned BORC_IRQ_BOR      = 0;
  localparam int unsigned BORC_IRQ_REL      = 1;
  localparam logic [1:0]  BORC_IRQ_MASK_RST = 2'h0;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic       powerup_delay_timer_enable;
    logic [1:0] brownout_threshold_cfg;
    logic [1:0] brownout_enable_cfg;
  } borc_cfg_s;

  typedef enum logic [1:0] {
    BORC_RUN,
    BORC_FILTER,
    BORC_BROWNOUT,
    BORC_POWERUP_DELAY_TIMER
  } borc_state_e;

endpackage

/* File: verilog/borc_sync3.sv */
// borc_sync3: three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module borc_sync3 (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // async level in, filtered level out
  input  wire logic async_i,
  input  wire logic reset_val_i,
  output logic      level_o
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic level_next;

  // ------------------------------------------------------------
  // next value
  // ------------------------------------------------------------
  // s1 feeds only s2, so a metastable s1 never reaches logic
  always_comb begin
    level_next = level_reg;
    if (s2_reg == s3_reg) begin
      level_next = s3_reg;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      s1_reg    <= async_i;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level_o = level_reg;

endmodule
`default_nettype wire

/* File: verilog/borc_top.sv */
// borc_top: brown-out reset control with wishbone register access
//
// Behaviour
// - While detection is enabled, the device is reset once the supply stays low past the minimum duration.
// - A brown-out reset lasts as long as the supply stays below the threshold.
// - With the power-up timer on, reset is held the full delay after the supply recovers.
// - A supply drop during the power-up delay returns to brown-out and restarts the delay afterwards.
// - Brown-out enable and power-up timer enable are separate settings.
// - Setting 01 gates detection with the software enable at bit 6 of the reset control register.
// - Outside setting 01 the software enable does nothing and reads 0.
// - The threshold comes only from its configuration field, never from software.
// - While enabled, every brown-out or power-on reset clears the brown-out status flag.
// - Setting 10 detects in run and idle, stops in sleep and resumes on leaving it.
// - Setting 00 stays off and 11 stays on in every mode until reconfigured.
`timescale 1ns/1ps
`default_nettype none
module borc_top
  import borc_pkg::*;
#(
  parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = BORC_POWERUP_DELAY_TIMER_CYC
) (
  // clock and power-on reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // configuration bits and power state
  input  wire borc_cfg_s   cfg_i,
  input  wire logic        sleep_i,
  // supply monitor
  input  wire logic        supply_low_i,
  output logic [1:0]       threshold_sel_o,
  // device reset and interrupt
  output logic             brownout_reset_o,
  output logic             irq_o,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic                  supply_low;
  logic                  det_en;
  borc_state_e           state_reg;
  borc_state_e           state_next;
  logic [BORC_CNT_W-1:0] cnt_reg;
  logic [BORC_CNT_W-1:0] cnt_next;
  logic                  rst_out_reg;
  logic                  rst_out_next;
  logic                  evt_bor;
  logic                  evt_rel;
  logic                  swen_reg;
  logic                  swen_next;
  logic                  borf_reg;
  logic                  borf_next;
  logic                  porf_reg;
  logic                  porf_next;
  logic [1:0]            thr_reg;
  logic [1:0]            irq_stat_reg;
  logic [1:0]            irq_stat_next;
  logic [1:0]            irq_mask_reg;
  logic [1:0]            irq_mask_next;
  logic                  irq_reg;
  logic                  ack_reg;
  logic                  ack_next;
  logic [31:0]           dat_reg;
  logic [31:0]           dat_next;
  logic                  wr_lane0;
  logic                  swen_rd;

  // ------------------------------------------------------------
  // supply-low synchroniser
  // ------------------------------------------------------------
  borc_sync3 u_sync (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .async_i     (supply_low_i),
    .reset_val_i (1'b0),
    .level_o     (supply_low)
  );

  // ------------------------------------------------------------
  // detection enable
  // ------------------------------------------------------------
  always_comb begin
    case (cfg_i.brownout_enable_cfg)
      BORC_EN_OFF:   det_en = 1'b0;
      BORC_EN_SW:    det_en = swen_reg;
      BORC_EN_NOSLP: det_en = !sleep_i;
      BORC_EN_ON:    det_en = 1'b1;
      default:       det_en = 1'b0;
    endcase
  end

  // software enable only means anything in software mode
  assign swen_rd = (cfg_i.brownout_enable_cfg == BORC_EN_SW) ? swen_reg : 1'b0;

  // ------------------------------------------------------------
  // reset sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    evt_bor      = 1'b0;
    evt_rel      = 1'b0;
    case (state_reg)
      BORC_RUN: begin
        if (det_en && supply_low) begin
          state_next = BORC_FILTER;
          cnt_next   = BORC_CNT_W'(1);
        end
      end
      BORC_FILTER: begin
        // short dips are ignored: only a low lasting past the minimum resets
        if (!det_en || !supply_low) begin
          state_next = BORC_RUN;
        end else if (cnt_reg >= BORC_CNT_W'(BORC_MIN_DUR_CYC)) begin
          state_next = BORC_BROWNOUT;
          evt_bor    = 1'b1;
        end else begin
          cnt_next = cnt_reg + BORC_CNT_W'(1);
        end
      end
      BORC_BROWNOUT: begin
        // once begun, only recovery ends it, even if detection is disabled
        if (!supply_low) begin
          cnt_next = BORC_CNT_W'(1);
          if (cfg_i.powerup_delay_timer_enable) begin
            state_next = BORC_POWERUP_DELAY_TIMER;
          end else begin
            state_next = BORC_RUN;
            evt_rel    = 1'b1;
          end
        end
      end
      BORC_POWERUP_DELAY_TIMER: begin
        if (supply_low) begin
          state_next = BORC_BROWNOUT;
          cnt_next   = BORC_CNT_W'(1);
        end else if (cnt_reg >= BORC_CNT_W'(POWERUP_DELAY_TIMER_CYCLES)) begin
          state_next = BORC_RUN;
          evt_rel    = 1'b1;
        end else begin
          cnt_next = cnt_reg + BORC_CNT_W'(1);
        end
      end
      default: begin
        state_next = BORC_RUN;
      end
    endcase
    rst_out_next = (state_next == BORC_BROWNOUT) || (state_next == BORC_POWERUP_DELAY_TIMER);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg   <= BORC_RUN;
      cnt_reg     <= '0;
      rst_out_reg <= 1'b0;
      thr_reg     <= 2'h0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      rst_out_reg <= rst_out_next;
      thr_reg     <= cfg_i.brownout_threshold_cfg;
    end
  end

  // ------------------------------------------------------------
  // registers and wishbone slave
  // ------------------------------------------------------------
  // writes land on the edge where ack is high, as the master expects
  assign wr_lane0 = cyc_i && stb_i && we_i && ack_reg && sel_i[0];

  always_comb begin
    ack_next      = cyc_i && stb_i && !ack_reg;
    dat_next      = dat_reg;
    swen_next     = swen_reg;
    borf_next     = borf_reg;
    porf_next     = porf_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    if (cyc_i && stb_i && !ack_reg) begin
      dat_next = 32'h0;
      case (adr_i)
        BORC_ADR_CTRL: begin
          dat_next[BORC_CTRL_SWEN] = swen_rd;
          dat_next[BORC_CTRL_BORF] = borf_reg;
          dat_next[BORC_CTRL_PORF] = porf_reg;
        end
        BORC_ADR_CFG: begin
          dat_next[4:0] = cfg_i;
        end
        BORC_ADR_STATUS: begin
          dat_next[BORC_ST_LOW]    = supply_low;
          dat_next[BORC_ST_DET_EN] = det_en;
          dat_next[BORC_ST_RESET]  = rst_out_reg;
          dat_next[BORC_ST_STATE_LSB +: 2] = state_reg;
        end
        BORC_ADR_IRQ_STAT: dat_next[1:0] = irq_stat_reg;
        BORC_ADR_IRQ_MASK: dat_next[1:0] = irq_mask_reg;
        default:           dat_next = 32'h0;
      endcase
    end
    if (wr_lane0) begin
      case (adr_i)
        BORC_ADR_CTRL: begin
          if (cfg_i.brownout_enable_cfg == BORC_EN_SW) begin
            swen_next = dat_i[BORC_CTRL_SWEN];
          end
          borf_next = dat_i[BORC_CTRL_BORF];
          porf_next = dat_i[BORC_CTRL_PORF];
        end
        BORC_ADR_IRQ_STAT: irq_stat_next = irq_stat_reg & ~dat_i[1:0];
        BORC_ADR_IRQ_MASK: irq_mask_next = dat_i[1:0];
        default:           irq_mask_next = irq_mask_reg;
      endcase
    end
    // hardware set beats a software clear in the same cycle
    if (evt_bor) begin
      borf_next = 1'b0;
      irq_stat_next[BORC_IRQ_BOR] = 1'b1;
    end
    if (evt_rel) begin
      irq_stat_next[BORC_IRQ_REL] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg      <= 1'b0;
      dat_reg      <= 32'h0;
      swen_reg     <= BORC_SWEN_RST;
      borf_reg     <= BORC_BORF_RST;
      porf_reg     <= BORC_PORF_RST;
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= BORC_IRQ_MASK_RST;
      irq_reg      <= 1'b0;
    end else begin
      ack_reg      <= ack_next;
      dat_reg      <= dat_next;
      swen_reg     <= swen_next;
      borf_reg     <= borf_next;
      porf_reg     <= porf_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg      <= |(irq_stat_next & irq_mask_next);
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign brownout_reset_o = rst_out_reg;
  assign threshold_sel_o  = thr_reg;
  assign irq_o            = irq_reg;
  assign ack_o            = ack_reg;
  assign dat_o            = dat_reg;

endmodule
`default_nettype wire

/* File: tb/borc_supply_model.sv */
// borc_supply_model: supply comparator that sits outside the brown-out block
`timescale 1ns/1ps
`default_nettype none
module borc_supply_model #(
  parameter int unsigned THR_BASE_MV = 2000,
  parameter int unsigned THR_STEP_MV = 500,
  parameter int unsigned LAG_NS      = 7
) (
  // supply level and selected threshold
  input  wire logic [15:0] vdd_mv_i,
  input  wire logic [1:0]  threshold_sel_i,
  // comparator output, not tied to the clock
  output logic             supply_low_o
);
  initial supply_low_o = 1'b0;
  // lag puts edges between clock edges, so the sync stages see real skew
  always @(vdd_mv_i or threshold_sel_i) begin
    supply_low_o <= #(LAG_NS) (32'(vdd_mv_i) < THR_BASE_MV + THR_STEP_MV * 32'(threshold_sel_i));
  end
endmodule
`default_nettype wire

/* File: tb/borc_top_asserts.sv */
// borc_top_asserts: port checks for the brown-out reset control
`timescale 1ns/1ps
`default_nettype none
module borc_top_asserts
  import borc_pkg::*;
#(
  parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = BORC_POWERUP_DELAY_TIMER_CYC
) (
  // clock, config, supply, reset out
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire borc_cfg_s   cfg_i,
  input wire logic        supply_low_i,
  input wire logic [1:0]  threshold_sel_o,
  input wire logic        brownout_reset_o,
  // wishbone
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] ok_cnt_reg;
  logic [15:0] ok_cnt_next;
  // cycles of good supply while reset is still held
  always_comb begin
    ok_cnt_next = ok_cnt_reg;
    if (!brownout_reset_o || supply_low_i) begin
      ok_cnt_next = 16'h0;
    end else if (ok_cnt_reg != 16'hFFFF) begin
      ok_cnt_next = ok_cnt_reg + 16'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    ok_cnt_reg <= rst_i ? 16'h0 : ok_cnt_next;
  end
  sequence low_on_s;
    cfg_i.brownout_enable_cfg == BORC_EN_ON && supply_low_i;
  endsequence
  sequence rd_s;
    cyc_i && stb_i && !we_i && !ack_o;
  endsequence
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acked");
  thr_copy_a: assert property (!rst_i |=> threshold_sel_o == $past(cfg_i.brownout_threshold_cfg))
    else $error("threshold not from config");
  off_quiet_a: assert property ((cfg_i.brownout_enable_cfg == BORC_EN_OFF && !brownout_reset_o)[*3]
    |=> !brownout_reset_o) else $error("reset while disabled");
  hold_low_a: assert property (supply_low_i[*4] ##0 brownout_reset_o |=> brownout_reset_o)
    else $error("reset released while supply low");
  enter_reset_a: assert property (low_on_s[*8] ##1 low_on_s[*6] |-> brownout_reset_o)
    else $error("no reset after long low supply");
  swen_read_a: assert property (rd_s ##0 adr_i == BORC_ADR_CTRL &&
    cfg_i.brownout_enable_cfg != BORC_EN_SW |=> !dat_o[BORC_CTRL_SWEN]) else $error("sw enable reads 1");
  cfg_read_a: assert property (rd_s ##0 adr_i == BORC_ADR_CFG |=> dat_o == {27'h0, $past(cfg_i)})
    else $error("config readback wrong");
  powerup_delay_timer_full_a: assert property ($fell(brownout_reset_o) && cfg_i.powerup_delay_timer_enable |-> ok_cnt_reg >= POWERUP_DELAY_TIMER_CYCLES)
    else $error("power-up delay cut short");
endmodule
bind borc_top borc_top_asserts #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES)) u_borc_top_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg_i), .supply_low_i(supply_low_i),
  .threshold_sel_o(threshold_sel_o), .brownout_reset_o(brownout_reset_o), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o));
`default_nettype wire

/* File: tb/borc_tb_top.sv */
// borc_tb_top: scenario testbench for the brown-out reset control
`timescale 1ns/1ps
`default_nettype none
module borc_tb_top
  import borc_pkg::*;
;
  localparam int unsigned PW    = 10;
  localparam logic [15:0] V_LOW = 16'h03E8;
  localparam logic [15:0] V_OK  = 16'h1388;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  borc_cfg_s   cfg_i   = '{1'b0, 2'h2, BORC_EN_SW};
  logic        sleep_i = 1'b0;
  logic [15:0] vdd_mv  = V_OK;
  logic        cyc_i   = 1'b0;
  logic        stb_i   = 1'b0;
  logic        we_i    = 1'b0;
  logic [7:0]  adr_i   = 8'h00;
  logic [3:0]  sel_i   = 4'h0;
  logic [31:0] dat_i   = 32'h0;
  logic        supply_low;
  logic [1:0]  threshold_sel_o;
  logic        brownout_reset_o;
  logic        irq_o;
  logic [31:0] dat_o;
  logic        ack_o;
  int          fail_count = 0;
  int          n_compared = 0;
  always #25 clk_i = ~clk_i;
  borc_supply_model u_borc_supply_model (.vdd_mv_i(vdd_mv), .threshold_sel_i(threshold_sel_o),
    .supply_low_o(supply_low));
  borc_top #(.POWERUP_DELAY_TIMER_CYCLES(PW)) u_borc_top (.clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg_i), .sleep_i(sleep_i),
    .supply_low_i(supply_low), .threshold_sel_o(threshold_sel_o), .brownout_reset_o(brownout_reset_o),
    .irq_o(irq_o), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // entered just after a rising edge; waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int i;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) break;
    end
    if (i == 20) begin
      fail_count++;
      print_verdict();
    end
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask
  task automatic wait_rst(input logic v, input int n, output int c);
    for (c = 0; c < n; c++) begin
      if (brownout_reset_o === v) break;
      @(posedge clk_i);
    end
    // a wait that runs out is a mismatch and ends the run
    if (c == n) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic t_regs();
    logic [31:0] r;
    wb(1'b0, BORC_ADR_CTRL, 32'h0, r);
    chk(r, 32'h40);
    wr(BORC_ADR_CFG, 32'h1F);
    wb(1'b0, BORC_ADR_CFG, 32'h0, r);
    chk(r, {27'h0, cfg_i});
    chk(threshold_sel_o, 2'h2);
    wb(1'b0, 8'h14, 32'h0, r);
    chk(r, 32'h0);
    wr(BORC_ADR_CTRL, 32'h43);
    wb(1'b0, BORC_ADR_CTRL, 32'h0, r);
    chk(r, 32'h43);
  endtask
  task automatic t_sw();
    logic [31:0] r;
    int c;
    wr(BORC_ADR_IRQ_MASK, 32'h1);
    wr(BORC_ADR_CTRL, 32'h02);
    vdd_mv <= V_LOW;
    repeat (30) @(posedge clk_i);
    chk(brownout_reset_o, 1'b0);
    vdd_mv <= V_OK;
    repeat (8) @(posedge clk_i);
    wr(BORC_ADR_CTRL, 32'h43);
    vdd_mv <= V_LOW;
    wait_rst(1'b1, 30, c);
    chk(brownout_reset_o, 1'b1);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 1'b1);
    wb(1'b0, BORC_ADR_CTRL, 32'h0, r);
    chk(r[1:0], 2'h2);
    vdd_mv <= V_OK;
    wait_rst(1'b0, 30, c);
    chk(c < 10, 1'b1);
    wr(BORC_ADR_IRQ_STAT, 32'h3);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
  endtask
  // off, sleep in mode 10, awake in mode 10, sleep in mode 11
  task automatic t_modes();
    logic [1:0]  md [4] = '{BORC_EN_OFF, BORC_EN_NOSLP, BORC_EN_NOSLP, BORC_EN_ON};
    logic [3:0]  slp = 4'hA;
    logic [3:0]  exp = 4'hC;
    logic [31:0] r;
    int c;
    for (int i = 0; i < 4; i++) begin
      cfg_i.brownout_enable_cfg <= md[i];
      sleep_i <= slp[i];
      repeat (4) @(posedge clk_i);
      vdd_mv <= V_LOW;
      repeat (30) @(posedge clk_i);
      chk(brownout_reset_o, exp[i]);
      wb(1'b0, BORC_ADR_CTRL, 32'h0, r);
      chk(r[6], 1'b0);
      vdd_mv <= V_OK;
      wait_rst(1'b0, 30, c);
      chk(brownout_reset_o, 1'b0);
    end
  endtask
  task automatic t_powerup_delay_timer();
    int c;
    cfg_i <= '{1'b1, 2'h1, BORC_EN_ON};
    sleep_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(threshold_sel_o, 2'h1);
    vdd_mv <= V_LOW;
    wait_rst(1'b1, 30, c);
    vdd_mv <= V_OK;
    repeat (6) @(posedge clk_i);
    vdd_mv <= V_LOW;
    repeat (12) @(posedge clk_i);
    chk(brownout_reset_o, 1'b1);
    vdd_mv <= V_OK;
    wait_rst(1'b0, PW + 40, c);
    chk(c >= PW && c <= PW + 8, 1'b1);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_sw();
    t_modes();
    t_powerup_delay_timer();
    print_verdict();
  end
endmodule
`default_nettype wire
